// ===== css_pkg.sv
// Package for the clock source select and switch block: types, offsets, reset values, timing.
// Assumes a 250 MHz system clock and an AXI4-Lite master with 8-bit byte addresses.
`default_nettype none
package css_pkg;

   // ****************************************************************
   // Register map (byte addresses) and reset values
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_STATUS    = 8'h04;
   localparam logic [7:0] OFS_TRIM      = 8'h08;
   localparam logic [7:0] OFS_PINCTL    = 8'h0c;
   localparam logic [6:0] CTRL_RST      = 7'h00;
   localparam logic [7:0] TRIM_RST      = 8'h00;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // ****************************************************************
   // Timing: internal oscillator model as a phase accumulator
   // ****************************************************************
   localparam int unsigned CLK_KHZ      = 250000;
   localparam int unsigned IFS0_KHZ     = 4000;
   localparam int unsigned IFS1_KHZ     = 8000;
   localparam int unsigned IFS2_KHZ     = 12800;
   localparam int unsigned IFS3_KHZ     = 25600;
   localparam int unsigned NCO_W        = 16;
   localparam logic [23:0] INC_IFS0     = 24'((IFS0_KHZ * 65536 + CLK_KHZ / 2) / CLK_KHZ);
   localparam logic [23:0] INC_IFS1     = 24'((IFS1_KHZ * 65536 + CLK_KHZ / 2) / CLK_KHZ);
   localparam logic [23:0] INC_IFS2     = 24'((IFS2_KHZ * 65536 + CLK_KHZ / 2) / CLK_KHZ);
   localparam logic [23:0] INC_IFS3     = 24'((IFS3_KHZ * 65536 + CLK_KHZ / 2) / CLK_KHZ);
   localparam logic [23:0] TRIM_UNITY   = 24'h000200;
   localparam int unsigned TRIM_SHIFT   = 9;
   localparam logic [1:0]  EDGES_NEEDED = 2'h2;

   // ****************************************************************
   // Enumerations
   // ****************************************************************
   typedef enum logic [1:0] {SRC_INT = 2'h0, SRC_EXT = 2'h1, SRC_RC = 2'h2, SRC_XTAL = 2'h3} css_src_t;
   typedef enum logic [2:0] {SW_INT = 3'b001, SW_WAIT = 3'b010, SW_EXT = 3'b100} css_sw_t;
   typedef enum logic [1:0] {AUX_GPIO = 2'h0, AUX_CLKOUT = 2'h1, AUX_XTAL = 2'h2} css_aux_t;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic       external_clock_enable;
      logic [1:0] crystal_range_select;
      logic [1:0] internal_freq_select;
      css_src_t   clock_source_option;
   } css_ctrl_t;

   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } css_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } css_axi_rsp_t;

   typedef struct packed {
      logic crystal_source_clock;
      logic rc_source_clock;
      logic clock_in_pin;
   } css_srcclk_t;

endpackage
`default_nettype wire

// ===== css_sync.sv
// Two-stage synchroniser for the source clocks arriving from outside the system clock domain.
// Assumes nothing reads the first stage except the second stage.
`timescale 1ns/1ps
`default_nettype none
module css_sync (
   input  wire logic                 CLOCK,
   input  wire logic                 SYS_RST,
   input  wire css_pkg::css_srcclk_t ASYNC_IN,
   output var  css_pkg::css_srcclk_t SYNC_OUT
);
   import css_pkg::*;

   typedef struct packed {
      css_srcclk_t stage1;
      css_srcclk_t stage2;
   } css_sync_state_t;

   css_sync_state_t st_ff;
   css_sync_state_t nxt_st;

   // ****************************************************************
   // Stage shift
   // ****************************************************************
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.stage1 = ASYNC_IN;
      nxt_st.stage2 = st_ff.stage1;
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign SYNC_OUT = st_ff.stage2;
endmodule
`default_nettype wire

// ===== css_top.sv
// Clock source select and glitch-free switch, with AXI4-Lite register access.
// Assumes source clocks are far slower than CLOCK; the system unit drives STOP_OSC_ENABLE_IN on CLOCK.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Bus clock is source clock divided by four
// - Four internal frequencies, 4 MHz after reset
// - Times-four clock equals selected source frequency
// - Times-two clock is half times-four
// - Stop enable gates oscillators unless keep-alive
// - Signed 8-bit trim; larger value, slower clock
// - Factory trim never loaded automatically
// - Two external rising edges before switching
// - Set engaged first, then stop internal
// - External option enables pin; crystal drives aux
// - Clearing option and enable returns internal
// - External mode forces clock-out enable clear
// - Crystal mode dedicates aux pin to crystal
// - Internal or RC with clock-out enable set: aux outputs times-four clock, else GPIO
// - Source codes: internal, external, RC, crystal
// - Frequency codes 4.0, 8.0, 12.8, 25.6 MHz
// - Engaged status reads 1 on external source
module css_top (
   input  wire logic                  CLOCK,
   input  wire logic                  SYS_RST,
   input  wire css_pkg::css_axi_req_t AXI_REQ,
   output var  css_pkg::css_axi_rsp_t AXI_RSP,
   input  wire css_pkg::css_srcclk_t  SOURCE_CLOCKS,
   input  wire logic                  STOP_OSC_ENABLE_IN,
   input  wire logic                  AUX_GPIO_O,
   input  wire logic                  AUX_GPIO_OE,
   output var  logic                  BUS_CLOCK_TIMES_FOUR,
   output var  logic                  BUS_CLOCK_TIMES_TWO,
   output var  logic                  BUS_CLOCK,
   output var  logic                  EXTERNAL_CLOCK_ENGAGED,
   output var  logic                  INTERNAL_OSC_RUN,
   output var  logic [7:0]            INTERNAL_OSC_TRIM,
   output var  logic                  CRYSTAL_OSC_ENABLE,
   output var  logic [1:0]            CRYSTAL_RANGE_SELECT,
   output var  logic                  RC_OSC_ENABLE,
   output var  logic                  CLOCK_IN_PIN_ENABLE,
   output var  css_pkg::css_aux_t     AUX_PIN_FUNC,
   output var  logic                  AUX_PIN_O,
   output var  logic                  AUX_PIN_OE
);
   import css_pkg::*;

   typedef struct packed {
      css_axi_rsp_t rsp;
      css_ctrl_t    ctrl;
      logic [7:0]   trim;
      logic         clkout_en;
      logic         keep_alive;
      css_sw_t      sw;
      logic [1:0]   edge_cnt;
      logic         engaged;
      logic [NCO_W-1:0] nco;
      logic         x4;
      logic         x2;
      logic         bus;
      css_srcclk_t  src_prev;
      logic         int_run;
      logic         xtal_en;
      logic         rc_en;
      logic         pin_en;
      css_aux_t     aux_func;
      logic         aux_o;
      logic         aux_oe;
   } css_top_state_t;

   css_top_state_t st_ff;
   css_top_state_t nxt_st;
   css_srcclk_t    src_sync;

   // ****************************************************************
   // Source clock synchroniser
   // ****************************************************************
   css_sync u_sync (
      .CLOCK    (CLOCK),
      .SYS_RST  (SYS_RST),
      .ASYNC_IN (SOURCE_CLOCKS),
      .SYNC_OUT (src_sync)
   );

   function automatic logic [31:0] rd_mux(input logic [7:0] addr, input css_top_state_t s);
      logic [31:0] d;
      d = 32'h0;
      case ({addr[7:2], 2'b00})
         OFS_CTRL:   d = {25'h0, s.ctrl};
         OFS_STATUS: d = {29'h0, s.int_run, s.sw == SW_WAIT, s.engaged};
         OFS_TRIM:   d = {24'h0, s.trim};
         OFS_PINCTL: d = {30'h0, s.keep_alive, s.clkout_en};
         default:    d = 32'h0;
      endcase
      return d;
   endfunction

   function automatic logic addr_ok(input logic [7:0] addr);
      logic [7:0] a;
      a = {addr[7:2], 2'b00};
      return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_TRIM) || (a == OFS_PINCTL);
   endfunction

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      logic        allowed;
      logic        ext_lvl;
      logic        ext_rise;
      logic        sel;
      logic [23:0] inc;
      logic [23:0] prod;
      logic [7:0]  wa;
      css_srcclk_t rise;
      nxt_st   = st_ff;
      allowed  = 1'b0;
      ext_lvl  = 1'b0;
      ext_rise = 1'b0;
      sel      = 1'b0;
      inc      = INC_IFS0;
      prod     = 24'h0;
      wa       = {AXI_REQ.awaddr[7:2], 2'b00};
      rise     = src_sync & ~st_ff.src_prev;

      // Bus slave, write path
      nxt_st.rsp.awready = 1'b0;
      nxt_st.rsp.wready  = 1'b0;
      nxt_st.rsp.arready = 1'b0;
      if (st_ff.rsp.bvalid && AXI_REQ.bready) begin
         nxt_st.rsp.bvalid = 1'b0;
      end
      if (!st_ff.rsp.awready && !st_ff.rsp.bvalid && AXI_REQ.awvalid && AXI_REQ.wvalid) begin
         nxt_st.rsp.awready = 1'b1;
         nxt_st.rsp.wready  = 1'b1;
      end
      if (st_ff.rsp.awready) begin
         nxt_st.rsp.bvalid = 1'b1;
         nxt_st.rsp.bresp  = addr_ok(AXI_REQ.awaddr) ? RESP_OKAY : RESP_SLVERR;
         if (AXI_REQ.wstrb[0]) begin
            case (wa)
               OFS_CTRL:   nxt_st.ctrl = css_ctrl_t'(AXI_REQ.wdata[6:0]);
               OFS_TRIM:   nxt_st.trim = AXI_REQ.wdata[7:0];
               OFS_PINCTL: begin
                  nxt_st.clkout_en  = AXI_REQ.wdata[0];
                  nxt_st.keep_alive = AXI_REQ.wdata[1];
               end
               default: ;
            endcase
         end
      end
      if (nxt_st.ctrl.clock_source_option == SRC_EXT) begin
         nxt_st.clkout_en = 1'b0;
      end

      // Bus slave, read path
      if (st_ff.rsp.rvalid && AXI_REQ.rready) begin
         nxt_st.rsp.rvalid = 1'b0;
      end
      if (!st_ff.rsp.arready && !st_ff.rsp.rvalid && AXI_REQ.arvalid) begin
         nxt_st.rsp.arready = 1'b1;
      end
      if (st_ff.rsp.arready) begin
         nxt_st.rsp.rvalid = 1'b1;
         nxt_st.rsp.rdata  = rd_mux(AXI_REQ.araddr, st_ff);
         nxt_st.rsp.rresp  = addr_ok(AXI_REQ.araddr) ? RESP_OKAY : RESP_SLVERR;
      end

      // External source pick
      nxt_st.src_prev = src_sync;
      case (st_ff.ctrl.clock_source_option)
         SRC_EXT: begin
            ext_lvl  = src_sync.clock_in_pin;
            ext_rise = rise.clock_in_pin;
         end
         SRC_RC: begin
            ext_lvl  = src_sync.rc_source_clock;
            ext_rise = rise.rc_source_clock;
         end
         SRC_XTAL: begin
            ext_lvl  = src_sync.crystal_source_clock;
            ext_rise = rise.crystal_source_clock;
         end
         default: begin
            ext_lvl  = 1'b0;
            ext_rise = 1'b0;
         end
      endcase

      // Switch sequencer
      case (st_ff.sw)
         SW_INT: begin
            if (st_ff.ctrl.external_clock_enable && st_ff.ctrl.clock_source_option != SRC_INT) begin
               nxt_st.sw       = SW_WAIT;
               nxt_st.edge_cnt = 2'h0;
            end
         end
         SW_WAIT: begin
            if (!st_ff.ctrl.external_clock_enable || st_ff.ctrl.clock_source_option == SRC_INT) begin
               nxt_st.sw = SW_INT;
            end else begin
               if (ext_rise && st_ff.edge_cnt < EDGES_NEEDED) begin
                  nxt_st.edge_cnt = st_ff.edge_cnt + 2'h1;
               end
               if (st_ff.edge_cnt >= EDGES_NEEDED && !st_ff.x4 && !ext_lvl) begin
                  nxt_st.engaged = 1'b1;
                  nxt_st.sw      = SW_EXT;
               end
            end
         end
         SW_EXT: begin
            if (!st_ff.ctrl.external_clock_enable && st_ff.ctrl.clock_source_option == SRC_INT) begin
               nxt_st.engaged = 1'b0;
               nxt_st.sw      = SW_INT;
            end
         end
         default: begin
            nxt_st.engaged = 1'b0;
            nxt_st.sw      = SW_INT;
         end
      endcase

      // Oscillator enables
      allowed          = STOP_OSC_ENABLE_IN || st_ff.keep_alive;
      nxt_st.int_run   = !st_ff.engaged && allowed;
      nxt_st.xtal_en   = (st_ff.ctrl.clock_source_option == SRC_XTAL) && allowed;
      nxt_st.rc_en     = (st_ff.ctrl.clock_source_option == SRC_RC) && allowed;
      nxt_st.pin_en    = nxt_st.ctrl.clock_source_option != SRC_INT;

      // Internal oscillator with trim
      case (st_ff.ctrl.internal_freq_select)
         2'h0:    inc = INC_IFS0;
         2'h1:    inc = INC_IFS1;
         2'h2:    inc = INC_IFS2;
         default: inc = INC_IFS3;
      endcase
      prod = inc * (TRIM_UNITY - {{16{st_ff.trim[7]}}, st_ff.trim});
      nxt_st.nco = st_ff.int_run ? st_ff.nco + prod[TRIM_SHIFT +: NCO_W] : '0;

      // Clock derivation
      sel       = st_ff.engaged ? ext_lvl : st_ff.nco[NCO_W-1];
      nxt_st.x4 = sel;
      if (sel && !st_ff.x4) begin
         nxt_st.x2 = !st_ff.x2;
         if (!st_ff.x2) begin
            nxt_st.bus = !st_ff.bus;
         end
      end

      // Auxiliary pin
      if (nxt_st.ctrl.clock_source_option == SRC_XTAL) begin
         nxt_st.aux_func = AUX_XTAL;
         nxt_st.aux_o    = !src_sync.clock_in_pin;
         nxt_st.aux_oe   = 1'b1;
      end else if (nxt_st.clkout_en) begin
         nxt_st.aux_func = AUX_CLKOUT;
         nxt_st.aux_o    = nxt_st.x4;
         nxt_st.aux_oe   = 1'b1;
      end else begin
         nxt_st.aux_func = AUX_GPIO;
         nxt_st.aux_o    = AUX_GPIO_O;
         nxt_st.aux_oe   = AUX_GPIO_OE;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         st_ff      <= '0;
         st_ff.sw   <= SW_INT;
         st_ff.ctrl <= css_ctrl_t'(CTRL_RST);
         st_ff.trim <= TRIM_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign AXI_RSP                = st_ff.rsp;
   assign BUS_CLOCK_TIMES_FOUR   = st_ff.x4;
   assign BUS_CLOCK_TIMES_TWO    = st_ff.x2;
   assign BUS_CLOCK              = st_ff.bus;
   assign EXTERNAL_CLOCK_ENGAGED = st_ff.engaged;
   assign INTERNAL_OSC_RUN       = st_ff.int_run;
   assign INTERNAL_OSC_TRIM      = st_ff.trim;
   assign CRYSTAL_OSC_ENABLE     = st_ff.xtal_en;
   assign CRYSTAL_RANGE_SELECT   = st_ff.ctrl.crystal_range_select;
   assign RC_OSC_ENABLE          = st_ff.rc_en;
   assign CLOCK_IN_PIN_ENABLE    = st_ff.pin_en;
   assign AUX_PIN_FUNC           = st_ff.aux_func;
   assign AUX_PIN_O              = st_ff.aux_o;
   assign AUX_PIN_OE             = st_ff.aux_oe;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   a_x2_half_rate: assert property ($changed(st_ff.x2) |-> $rose(st_ff.x4))
      else $error("times-two clock moved without a times-four rise");
   a_bus_quarter: assert property ($changed(st_ff.bus) |-> $rose(st_ff.x2))
      else $error("bus clock moved without a times-two rise");
   a_engage_after_wait: assert property ($rose(st_ff.engaged) |-> $past(st_ff.sw) == SW_WAIT
                                         && $past(st_ff.edge_cnt) == EDGES_NEEDED)
      else $error("engaged without two external edges");
   a_engage_then_stop: assert property ($rose(st_ff.engaged) && st_ff.int_run |=> !st_ff.int_run)
      else $error("internal oscillator not stopped after engage");
   a_wait_not_engaged: assert property (st_ff.sw != SW_EXT |-> !st_ff.engaged)
      else $error("engaged outside external state");
   a_stop_gating: assert property (!STOP_OSC_ENABLE_IN && !st_ff.keep_alive
                                   |=> !st_ff.int_run && !st_ff.xtal_en && !st_ff.rc_en)
      else $error("oscillator left running in stop");
   a_return_internal: assert property (st_ff.sw == SW_EXT && !st_ff.ctrl.external_clock_enable
                                       && st_ff.ctrl.clock_source_option == SRC_INT
                                       |=> !st_ff.engaged ##1 st_ff.int_run || !$past(STOP_OSC_ENABLE_IN))
      else $error("did not return to internal source");
   a_ext_no_clkout: assert property (st_ff.ctrl.clock_source_option == SRC_EXT
                                     |-> !st_ff.clkout_en && st_ff.aux_func != AUX_CLKOUT)
      else $error("clock-out enable set in external mode");
   a_aux_clkout: assert property (st_ff.aux_func == AUX_CLKOUT |-> st_ff.aux_o == st_ff.x4 && st_ff.aux_oe)
      else $error("aux pin not carrying times-four clock");
   a_pin_enable: assert property (st_ff.pin_en == (st_ff.ctrl.clock_source_option != SRC_INT))
      else $error("clock input pin enable wrong");
   a_xtal_aux: assert property (st_ff.ctrl.clock_source_option == SRC_XTAL |-> st_ff.aux_func == AUX_XTAL)
      else $error("aux pin not dedicated to crystal");
   a_reset_defaults: assert property ($fell(SYS_RST) |-> st_ff.trim == TRIM_RST
                                      && st_ff.ctrl.internal_freq_select == 2'h0)
      else $error("reset defaults wrong");

   c_engage: cover property ($rose(st_ff.engaged));
   c_return: cover property ($fell(st_ff.engaged));
   c_clkout: cover property (st_ff.aux_func == AUX_CLKOUT && $rose(st_ff.aux_o));
   c_abandon: cover property (st_ff.sw == SW_WAIT ##1 st_ff.sw == SW_INT);
endmodule
`default_nettype wire

// ===== css_far.sv
// Far-side model: external source clock and the stop enable of the system unit.
// Assumes the bench starts and stops the source clock through RUN.
`timescale 1ns/1ps
`default_nettype none
module css_far (
   input  wire logic                 CLOCK,
   input  wire logic                 RUN,
   input  wire logic                 STOP_REQ,
   output var  css_pkg::css_srcclk_t SRC,
   output var  logic                 STOP_OSC_ENABLE_IN
);
   import css_pkg::*;
   // ****
   // Source clock, stands low while stopped
   // ****
   localparam int HALF_NS = 24;
   logic osc = 1'b0;
   always begin
      #(HALF_NS);
      osc = RUN ? ~osc : 1'b0;
   end
   assign SRC = '{crystal_source_clock: osc, rc_source_clock: osc, clock_in_pin: osc};
   logic stop_en_q = 1'b1;
   always @(posedge CLOCK) begin
      stop_en_q <= ~STOP_REQ;
   end
   assign STOP_OSC_ENABLE_IN = stop_en_q;
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the clock source select block.
// Assumes css_far supplies the source clocks and the stop enable.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import css_pkg::*;
   logic         CLOCK = 1'b0;
   logic         SYS_RST = 1'b1;
   css_axi_req_t req = '0;
   css_axi_rsp_t rsp;
   css_srcclk_t  src;
   css_aux_t     aux_f;
   logic         stop_en, x4, x2, bclk, eng, irun, xo_en, rc_en, cin_en, aux_o, aux_oe;
   logic         run = 1'b0, stop_req = 1'b0, gp_o = 1'b0, gp_oe = 1'b0;
   logic [7:0]   trim;
   logic [1:0]   rng, rr;
   logic [31:0]  rd;
   int           failures = 0, checked = 0;
   always #2 CLOCK = ~CLOCK;
   css_top DUT (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .AXI_REQ(req), .AXI_RSP(rsp), .SOURCE_CLOCKS(src),
      .STOP_OSC_ENABLE_IN(stop_en), .AUX_GPIO_O(gp_o), .AUX_GPIO_OE(gp_oe), .BUS_CLOCK_TIMES_FOUR(x4),
      .BUS_CLOCK_TIMES_TWO(x2), .BUS_CLOCK(bclk), .EXTERNAL_CLOCK_ENGAGED(eng), .INTERNAL_OSC_RUN(irun),
      .INTERNAL_OSC_TRIM(trim), .CRYSTAL_OSC_ENABLE(xo_en), .CRYSTAL_RANGE_SELECT(rng),
      .RC_OSC_ENABLE(rc_en), .CLOCK_IN_PIN_ENABLE(cin_en), .AUX_PIN_FUNC(aux_f), .AUX_PIN_O(aux_o),
      .AUX_PIN_OE(aux_oe));
   css_far FAR (.CLOCK(CLOCK), .RUN(run), .STOP_REQ(stop_req), .SRC(src), .STOP_OSC_ENABLE_IN(stop_en));
   // ****
   // Shared tasks
   // ****
   task close_out;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task near(input int got, input int exp, input int tol);
      chk(32'(got >= exp - tol && got <= exp + tol), 32'h1);
   endtask
   task tmo(input int n, input int lim);
      if (n >= lim) begin
         failures++;
         $display("BAD %0t wait ran out", $time);
         close_out();
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw, bv;
      ta = 1'b0;
      tw = 1'b0;
      bv = 1'b0;
      @(posedge CLOCK);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      for (n = 0; n < 40 && !bv; n++) begin
         #1;
         ta = ta | (rsp.awready === 1'b1);
         tw = tw | (rsp.wready === 1'b1);
         bv = (rsp.bvalid === 1'b1);
         @(posedge CLOCK);
         if (ta) req.awvalid <= 1'b0;
         if (tw) req.wvalid <= 1'b0;
      end
      req.bready <= 1'b0;
      tmo(n, 40);
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
      int n;
      logic ar, rv;
      ar = 1'b0;
      rv = 1'b0;
      @(posedge CLOCK);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      for (n = 0; n < 40 && !rv; n++) begin
         #1;
         ar = ar | (rsp.arready === 1'b1);
         rv = (rsp.rvalid === 1'b1);
         rd = rsp.rdata;
         rr = rsp.rresp;
         @(posedge CLOCK);
         if (ar) req.arvalid <= 1'b0;
      end
      req.rready <= 1'b0;
      tmo(n, 40);
      chk(rd, exp);
      chk({30'h0, rr}, {30'h0, resp});
   endtask
   task meas(input int cyc, output int c4, output int c2, output int c1);
      logic p4, p2, p1;
      {c4, c2, c1} = '0;
      {p4, p2, p1} = {x4, x2, bclk};
      repeat (cyc) begin
         @(posedge CLOCK);
         #1;
         c4 += int'(x4 & ~p4);
         c2 += int'(x2 & ~p2);
         c1 += int'(bclk & ~p1);
         {p4, p2, p1} = {x4, x2, bclk};
      end
   endtask
   // ****
   // Scenarios
   // ****
   task t_reset;
      rchk(OFS_CTRL, {25'h0, CTRL_RST}, RESP_OKAY);
      rchk(OFS_TRIM, {24'h0, TRIM_RST}, RESP_OKAY);
      rchk(OFS_STATUS, 32'h4, RESP_OKAY);
      rchk(8'h10, 32'h0, RESP_SLVERR);
      chk({24'h0, trim}, 32'h0);
   endtask
   task t_freq;
      int f [4] = '{IFS0_KHZ, IFS1_KHZ, IFS2_KHZ, IFS3_KHZ};
      int c4, c2, c1, i;
      for (i = 0; i < 4; i++) begin
         wr(OFS_CTRL, 32'(i << 2));
         idle(4);
         meas(2500, c4, c2, c1);
         near(c4, f[i] / 100, 2);
         near(c2, f[i] / 200, 2);
         near(c1, f[i] / 400, 2);
      end
      wr(OFS_TRIM, 32'h7f);
      idle(4);
      meas(2500, c4, c2, c1);
      near(c4, 192, 3);
      chk({24'h0, trim}, 32'h7f);
      wr(OFS_TRIM, 32'h80);
      idle(4);
      meas(2500, c4, c2, c1);
      near(c4, 320, 3);
      wr(OFS_TRIM, 32'h0);
      wr(OFS_CTRL, 32'h0);
   endtask
   task t_aux;
      gp_o <= 1'b1;
      gp_oe <= 1'b1;
      idle(4);
      chk({28'h0, aux_f, aux_o, aux_oe}, {28'h0, AUX_GPIO, 2'b11});
      wr(OFS_CTRL, 32'h13);
      gp_o <= 1'b0;
      gp_oe <= 1'b0;
      idle(4);
      chk({26'h0, aux_f, aux_o, aux_oe, xo_en, cin_en}, {26'h0, AUX_XTAL, 4'hf});
      chk({30'h0, rng}, 32'h1);
      wr(OFS_PINCTL, 32'h1);
      idle(4);
      chk({30'h0, aux_f}, {30'h0, AUX_XTAL});
      wr(OFS_CTRL, 32'h2);
      idle(4);
      chk({29'h0, aux_f, rc_en}, {29'h0, AUX_CLKOUT, 1'b1});
      chk({31'h0, aux_o}, {31'h0, x4});
      wr(OFS_CTRL, 32'h0);
      wr(OFS_PINCTL, 32'h0);
   endtask
   task t_stop;
      stop_req <= 1'b1;
      idle(6);
      chk({31'h0, irun}, 32'h0);
      wr(OFS_PINCTL, 32'h2);
      idle(4);
      chk({31'h0, irun}, 32'h1);
      wr(OFS_PINCTL, 32'h0);
      stop_req <= 1'b0;
      idle(4);
      chk({31'h0, irun}, 32'h1);
   endtask
   task t_ext;
      int n, c4, c2, c1;
      wr(OFS_PINCTL, 32'h1);
      wr(OFS_CTRL, 32'h1);
      idle(4);
      rchk(OFS_PINCTL, 32'h0, RESP_OKAY);
      chk({29'h0, aux_f, cin_en}, {29'h0, AUX_GPIO, 1'b1});
      idle(64);
      wr(OFS_CTRL, 32'h41);
      idle(100);
      rchk(OFS_STATUS, 32'h6, RESP_OKAY);
      chk({30'h0, eng, irun}, 32'h1);
      wr(OFS_CTRL, 32'h1);
      rchk(OFS_STATUS, 32'h4, RESP_OKAY);
      wr(OFS_CTRL, 32'h41);
      run <= 1'b1;
      for (n = 0; n < 300 && eng !== 1'b1; n++) begin
         @(posedge CLOCK);
         #1;
      end
      tmo(n, 300);
      chk(32'(n >= 18), 32'h1);
      chk({31'h0, irun}, 32'h1);
      @(posedge CLOCK);
      #1;
      chk({31'h0, irun}, 32'h0);
      meas(2500, c4, c2, c1);
      near(c4, 208, 3);
      near(c1, 52, 2);
      rchk(OFS_STATUS, 32'h1, RESP_OKAY);
      wr(OFS_CTRL, 32'h0);
      idle(4);
      chk({30'h0, eng, irun}, 32'h1);
      run <= 1'b0;
   endtask
   initial begin
      repeat (5) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      t_reset();
      t_freq();
      t_aux();
      t_stop();
      t_ext();
      close_out();
   end
endmodule
`default_nettype wire
